// >>> logic/tws_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, built from flip-flops.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] fill;
	} tws_fifo_state_t;

	tws_fifo_state_t s_r;
	tws_fifo_state_t s_nxt;
	logic push;
	logic pop;

	// Full and empty come straight from the fill level.
	assign in_ready = (s_r.fill != (PW+1)'(DEPTH));
	assign out_valid = (s_r.fill != '0);
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and storage update; wraps at DEPTH so any depth of two or more works.
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = (s_r.wp == PW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == PW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		end
		s_nxt.fill = s_r.fill + (PW+1)'(push) - (PW+1)'(pop);
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // tws_fifo

`default_nettype wire

// >>> logic/tws_pkg.sv
/*
 * Types shared by the triggered write sequencer modules.
 * Assumes tws_regs.svh is on the include path.
 */
`default_nettype none
`include "tws_regs.svh"

package tws_pkg;

	// Stream side state: between frames or inside one.
	typedef enum logic {TWS_FR_IDLE, TWS_FR_ACTIVE} tws_frame_t;

	// Write engine state.
	typedef enum logic {TWS_WR_IDLE, TWS_WR_ISSUE} tws_wr_t;

	// Whole state of the top module.
	typedef struct packed {
		logic go;
		logic irq_en;
		tws_frame_t frame;
		logic run;
		logic irq_done;
		logic irq_out;
		logic inhibit;
		logic [31:0] count;
		logic [`TWS_NUM_PAIRS-1:0][31:0] addr;
		logic [`TWS_NUM_PAIRS-1:0][31:0] word;
		logic [31:0] rdata;
		logic rvalid;
	} tws_top_state_t;

	// Whole state of the write engine.
	typedef struct packed {
		tws_wr_t st;
		logic [`TWS_IDX_W-1:0] idx;
		logic [`TWS_IDX_W-1:0] last;
		logic [31:0] addr;
		logic [31:0] data;
		logic done;
	} tws_wr_state_t;

endpackage

`default_nettype wire

// >>> logic/tws_regs.svh
/*
 * Register offsets, field positions, reset values and sizes of the triggered write sequencer.
 * Assumes it is included by its bare name, after the including file's header comment.
 */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// Word offsets on the register port.
`define TWS_OFS_CONTROL 5'h00
`define TWS_OFS_STATUS 5'h01
`define TWS_OFS_IRQ 5'h02
`define TWS_OFS_INHIBIT 5'h03
`define TWS_OFS_COUNT 5'h04
`define TWS_OFS_TABLE_BASE 5'h05
`define TWS_OFS_TABLE_LAST 5'h18

// Field positions.
`define TWS_CTRL_GO_BIT 0
`define TWS_CTRL_IRQ_EN_BIT 1
`define TWS_STATUS_RUN_BIT 0
`define TWS_IRQ_DONE_BIT 1

// Sizes and reset values.
`define TWS_ADDR_W 5
`define TWS_NUM_PAIRS 10
`define TWS_IDX_W 4
`define TWS_PIX_W 24
`define TWS_FIFO_DEPTH 8
`define TWS_RST_WORD 32'h00000000

`endif

// >>> logic/tws_top.sv
/*
 * Triggered write sequencer: register bank, video pass-through gate with its FIFO,
 * and trigger handling that starts a programmed run of up to ten writes.
 *
 * Register map, one 32-bit word per offset on the register port:
 *   Offset 0x00, run_control: bit 0 enables the run and bit 1 the completion interrupt.
 *   Offset 0x01, run_status: bit 0 shows the running state; writes are dropped.
 *   Offset 0x02, completion_irq_flag: bit 1 is the pending completion, cleared by writing 1.
 *   Offset 0x03, trigger_inhibit: bit 0 makes the block ignore its trigger input.
 *   Offset 0x04, write_count: writes per trigger, where anything above ten counts as ten.
 *   Offset 0x05 plus twice the index, target_addr_i: destination of write i.
 *   Offset 0x06 plus twice the index, write_value_i: data of write i.
 *   Offset 0x18 is write_value_9, the last mapped word.
 *   Offsets 0x19 to 0x1F are unmapped: they read as zero and writes are dropped.
 *
 * Timing on the register port:
 *   A write takes effect at the edge where its strobe is sampled.
 *   Read data and its valid flag stand for one cycle, one cycle after the read strobe.
 *   A read and a write in the same cycle return the old value.
 *
 * Timing on the master port:
 *   The first write goes out one cycle after an accepted trigger.
 *   Address, data and write strobe hold until the wait request is sampled low.
 *   The next pair follows one cycle after each acceptance.
 *   The completion flag and the interrupt both set two cycles after the last acceptance.
 *
 * Hazards for the user:
 *   The pair table is read live during a run, so change it only between runs.
 *   Triggers that arrive during a run or while inhibited are dropped without trace.
 *   A write count of zero issues no writes but still sets the completion flag.
 *
 * Assumes all inputs are synchronous to clk, the trigger input is a one-cycle pulse,
 * and the far side of the master port holds off with a wait request.
 */
// How it works
// - Every register is a full 32-bit word on the register port.
// - The run-enable bit is looked at only at a frame's first beat, so mid-frame writes take effect next frame.
// - Writing 1 to control bit 0 lets video frames flow through the block.
// - Control bit 1 enables the completion-of-writes interrupt output.
// - Status bit 0 shows the running state and all other status bits read zero.
// - Interrupt register bit 1 holds the pending completion flag and the rest read zero.
// - Writing 1 to interrupt bit 1 clears the pending completion flag.
// - While the trigger-inhibit register is 1 the trigger input is ignored.
// - While the trigger-inhibit register is 0 a trigger starts a write run, unless a run is already in flight.
// - With the re-arm option built in, each trigger that starts a run sets the trigger-inhibit register to 1 by itself.
// - A trigger issues as many writes as the write-count register says, ten at most, from pair 0 upward.
// - Ten target-address registers give the destination of the write of the same index.
// - Ten write-value registers give the data of the write of the same index.
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"

module tws_top #(
	parameter bit REARM_VIA_PORT = 1'b0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register port, word addressed, read data one cycle after the read strobe.
	input wire logic [`TWS_ADDR_W-1:0] reg_address,
	input wire logic reg_write,
	input wire logic [31:0] reg_writedata,
	input wire logic reg_read,
	output logic [31:0] reg_readdata,
	output logic reg_readdatavalid,
	// Trigger condition from the surrounding logic.
	input wire logic trigger_in,
	// Completion-of-writes interrupt.
	output logic irq,
	// Master write port.
	output logic [31:0] mst_address,
	output logic mst_write,
	output logic [31:0] mst_writedata,
	input wire logic mst_waitrequest,
	// Video input stream.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [`TWS_PIX_W-1:0] in_data,
	input wire logic in_sop,
	input wire logic in_eop,
	// Video output stream.
	output logic out_valid,
	input wire logic out_ready,
	output logic [`TWS_PIX_W-1:0] out_data,
	output logic out_sop,
	output logic out_eop
);
	localparam int FW = `TWS_PIX_W + 2;

	tws_pkg::tws_top_state_t s_r;
	tws_pkg::tws_top_state_t s_nxt;

	logic fifo_in_ready;
	logic fifo_in_valid;
	logic [FW-1:0] fifo_out_word;
	logic pass;
	logic start_ok;
	logic accept;
	logic wr_busy;
	logic wr_done;
	logic trig_fire;
	logic [`TWS_IDX_W-1:0] wr_num;
	logic wr_hit;
	logic wr_is_addr;
	logic [`TWS_IDX_W-1:0] wr_idx;
	logic rd_hit;
	logic rd_is_addr;
	logic [`TWS_IDX_W-1:0] rd_idx;

	// Maps an offset inside the pair table to hit, address-or-word and pair index.
	function automatic logic [`TWS_IDX_W+1:0] tws_table_decode(input logic [`TWS_ADDR_W-1:0] a);
		logic [`TWS_ADDR_W-1:0] rel;
		logic hit;
		rel = a - `TWS_OFS_TABLE_BASE;
		hit = (a >= `TWS_OFS_TABLE_BASE) && (a <= `TWS_OFS_TABLE_LAST);
		return {hit, ~rel[0], rel[`TWS_IDX_W:1]};
	endfunction

	// Table decode for the write and for the read side of the register port.
	assign {wr_hit, wr_is_addr, wr_idx} = tws_table_decode(reg_address);
	assign {rd_hit, rd_is_addr, rd_idx} = tws_table_decode(reg_address);

	// Limits the programmed count to the ten pairs that exist.
	assign wr_num = (s_r.count >= 32'(`TWS_NUM_PAIRS)) ? `TWS_IDX_W'(`TWS_NUM_PAIRS) : s_r.count[`TWS_IDX_W-1:0];

	// A trigger counts only when not inhibited and no run is in flight.
	assign trig_fire = trigger_in && !s_r.inhibit && !wr_busy;

	// Frames may start only at a first beat while run-enable is set; mid-frame beats always pass.
	assign start_ok = (s_r.frame == tws_pkg::TWS_FR_IDLE) && in_sop && s_r.go;
	assign pass = (s_r.frame == tws_pkg::TWS_FR_ACTIVE) || start_ok;
	assign fifo_in_valid = in_valid && pass;
	assign in_ready = fifo_in_ready && pass;
	assign accept = in_valid && in_ready;

	// Outputs taken from the state register and, for the video stream, from the FIFO.
	assign reg_readdata = s_r.rdata;
	assign reg_readdatavalid = s_r.rvalid;
	assign irq = s_r.irq_out;
	assign {out_sop, out_eop, out_data} = fifo_out_word;

	// Next-state logic for the register bank, stream gate and interrupt.
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = reg_read;

		// Software writes to the register bank.
		if (reg_write) begin
			case (reg_address)
				`TWS_OFS_CONTROL: begin
					s_nxt.go = reg_writedata[`TWS_CTRL_GO_BIT];
					s_nxt.irq_en = reg_writedata[`TWS_CTRL_IRQ_EN_BIT];
				end
				`TWS_OFS_IRQ: begin
					if (reg_writedata[`TWS_IRQ_DONE_BIT]) begin
						s_nxt.irq_done = 1'b0;
					end
				end
				`TWS_OFS_INHIBIT: begin
					s_nxt.inhibit = reg_writedata[0];
				end
				`TWS_OFS_COUNT: begin
					s_nxt.count = reg_writedata;
				end
				default: begin
					if (wr_hit && wr_is_addr) begin
						s_nxt.addr[wr_idx] = reg_writedata;
					end else if (wr_hit) begin
						s_nxt.word[wr_idx] = reg_writedata;
					end
				end
			endcase
		end

		// With REARM_VIA_PORT set, the block re-inhibits itself on each trigger that starts a run; this wins over a same-cycle software write.
		if (REARM_VIA_PORT && trig_fire) begin
			s_nxt.inhibit = 1'b1;
		end

		// Completion sets the flag; a set wins over a clear in the same cycle.
		if (wr_done) begin
			s_nxt.irq_done = 1'b1;
		end
		s_nxt.irq_out = s_nxt.irq_done && s_nxt.irq_en;

		// Stream frame tracking; a one-beat frame never leaves idle.
		if (accept && in_eop) begin
			s_nxt.frame = tws_pkg::TWS_FR_IDLE;
		end else if (accept && in_sop) begin
			s_nxt.frame = tws_pkg::TWS_FR_ACTIVE;
		end
		s_nxt.run = (s_nxt.frame == tws_pkg::TWS_FR_ACTIVE) || s_r.go;

		// Read data for the register port, zero for unmapped offsets and unused bits.
		s_nxt.rdata = `TWS_RST_WORD;
		if (reg_read) begin
			case (reg_address)
				`TWS_OFS_CONTROL: begin
					s_nxt.rdata[`TWS_CTRL_GO_BIT] = s_r.go;
					s_nxt.rdata[`TWS_CTRL_IRQ_EN_BIT] = s_r.irq_en;
				end
				`TWS_OFS_STATUS: begin
					s_nxt.rdata[`TWS_STATUS_RUN_BIT] = s_r.run;
				end
				`TWS_OFS_IRQ: begin
					s_nxt.rdata[`TWS_IRQ_DONE_BIT] = s_r.irq_done;
				end
				`TWS_OFS_INHIBIT: begin
					s_nxt.rdata[0] = s_r.inhibit;
				end
				`TWS_OFS_COUNT: begin
					s_nxt.rdata = s_r.count;
				end
				default: begin
					if (rd_hit && rd_is_addr) begin
						s_nxt.rdata = s_r.addr[rd_idx];
					end else if (rd_hit) begin
						s_nxt.rdata = s_r.word[rd_idx];
					end
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Write engine fed from the pair table.
	tws_writer u_writer (
		.clk(clk),
		.reset_n(reset_n),
		.start(trig_fire),
		.num(wr_num),
		.addr_tab(s_r.addr),
		.word_tab(s_r.word),
		.busy(wr_busy),
		.done(wr_done),
		.mst_address(mst_address),
		.mst_write(mst_write),
		.mst_writedata(mst_writedata),
		.mst_waitrequest(mst_waitrequest)
	);

	// Video buffer; when the output stalls it fills and holds off the input.
	tws_fifo #(
		.WIDTH(FW),
		.DEPTH(`TWS_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({in_sop, in_eop, in_data}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out_word)
	);

endmodule // tws_top

`default_nettype wire

// >>> logic/tws_writer.sv
/*
 * Write engine: issues a run of address/word writes on the master port, one at a time.
 * Assumes the table stays usable while busy and that the far side answers with a wait request.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"

module tws_writer (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Start request.
	input wire logic start,
	input wire logic [`TWS_IDX_W-1:0] num,
	input wire logic [`TWS_NUM_PAIRS-1:0][31:0] addr_tab,
	input wire logic [`TWS_NUM_PAIRS-1:0][31:0] word_tab,
	output logic busy,
	output logic done,
	// Master write port.
	output logic [31:0] mst_address,
	output logic mst_write,
	output logic [31:0] mst_writedata,
	input wire logic mst_waitrequest
);
	tws_pkg::tws_wr_state_t s_r;
	tws_pkg::tws_wr_state_t s_nxt;

	assign busy = (s_r.st == tws_pkg::TWS_WR_ISSUE);
	assign mst_write = busy;
	assign mst_address = s_r.addr;
	assign mst_writedata = s_r.data;
	assign done = s_r.done;

	// Walks the pairs from index 0 upward, holding each until accepted.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			tws_pkg::TWS_WR_IDLE: begin
				if (start) begin
					if (num == '0) begin
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.st = tws_pkg::TWS_WR_ISSUE;
						s_nxt.idx = '0;
						s_nxt.last = num - 1'b1;
						s_nxt.addr = addr_tab[0];
						s_nxt.data = word_tab[0];
					end
				end
			end
			tws_pkg::TWS_WR_ISSUE: begin
				if (!mst_waitrequest) begin
					if (s_r.idx == s_r.last) begin
						s_nxt.st = tws_pkg::TWS_WR_IDLE;
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.idx = s_r.idx + 1'b1;
						s_nxt.addr = addr_tab[s_r.idx + 1'b1];
						s_nxt.data = word_tab[s_r.idx + 1'b1];
					end
				end
			end
			default: begin
				s_nxt.st = tws_pkg::TWS_WR_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // tws_writer

`default_nettype wire

// >>> test/test_triggered_write_sequencer.sv
/* Top testbench of the triggered write sequencer.
   Assumes the design, the slave model and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"
module test_triggered_write_sequencer;
	logic clk, reset_n, reg_write, reg_read, reg_readdatavalid, trigger_in, irq, slow;
	logic mst_write, mst_waitrequest, in_valid, in_ready, in_sop, in_eop, out_valid, out_ready, out_sop, out_eop;
	logic [4:0] reg_address;
	logic [31:0] reg_writedata, reg_readdata, mst_address, mst_writedata;
	logic [23:0] in_data, out_data;
	int err_total, compares, cyc;
	bit ok;
	// The re-arm option is built in so that the self-inhibit on trigger is exercised.
	tws_top #(.REARM_VIA_PORT(1'b1)) i_dut (.clk, .reset_n, .reg_address, .reg_write, .reg_writedata,
		.reg_read, .reg_readdata,
		.reg_readdatavalid, .trigger_in, .irq, .mst_address, .mst_write, .mst_writedata, .mst_waitrequest,
		.in_valid, .in_ready, .in_data, .in_sop, .in_eop, .out_valid, .out_ready, .out_data, .out_sop, .out_eop);
	tws_slave_model i_slv (.clk, .reset_n, .mst_address, .mst_write, .mst_writedata, .mst_waitrequest, .slow);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 reg_address = a;
		reg_writedata = d;
		reg_write = 1'b1;
		@(posedge clk);
		#1 reg_write = 1'b0;
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		#1 reg_address = a;
		reg_read = 1'b1;
		@(posedge clk);
		#1 reg_read = 1'b0;
		chk("rvalid", reg_readdatavalid, 32'h1);
		chk("rdata", reg_readdata, e);
	endtask
	task automatic fire;
		@(posedge clk);
		#1 trigger_in = 1'b1;
		@(posedge clk);
		#1 trigger_in = 1'b0;
	endtask
	task automatic push(input logic [23:0] d, input logic s, e, output bit a);
		@(posedge clk);
		#1 in_valid = 1'b1;
		in_data = d;
		in_sop = s;
		in_eop = e;
		a = 1'b0;
		for (int i = 0; i < 4 && !a; i++) begin
			@(negedge clk);
			a = in_ready;
			@(posedge clk);
			#1;
		end
		in_valid = 1'b0;
	endtask
	task automatic pop(input logic [23:0] d, input logic s, e);
		@(negedge clk);
		for (int w = 0; w < 8 && out_valid !== 1'b1; w++)
			@(negedge clk);
		chk("ovalid", out_valid, 32'h1);
		chk("odata", out_data, d);
		chk("osop", out_sop, s);
		chk("oeop", out_eop, e);
		@(posedge clk);
		#1;
	endtask
	task automatic t_regs;
		rc(`TWS_OFS_CONTROL, 32'h0);
		wr(`TWS_OFS_STATUS, 32'hFFFFFFFF);
		rc(`TWS_OFS_STATUS, 32'h0);
		wr(5'h17, 32'hFFFFFFFF);
		rc(5'h17, 32'hFFFFFFFF);
		wr(5'h19, 32'hFFFFFFFF);
		rc(5'h19, 32'h0);
		wr(`TWS_OFS_CONTROL, 32'hFFFFFFFF);
		rc(`TWS_OFS_CONTROL, 32'h3);
		rc(`TWS_OFS_STATUS, 32'h1);
	endtask
	task automatic t_run(input int n, input logic s, input logic [31:0] ctl);
		int b;
		b = i_slv.n;
		slow = s;
		wr(`TWS_OFS_CONTROL, ctl);
		for (int i = 0; i < n; i++) begin
			wr(5'(`TWS_OFS_TABLE_BASE + 2 * i), 32'hA0000100 + i);
			wr(5'(`TWS_OFS_TABLE_BASE + 1 + 2 * i), 32'h5A5A0000 + i);
		end
		wr(`TWS_OFS_COUNT, n);
		wr(`TWS_OFS_INHIBIT, 32'h0);
		fire;
		for (int w = 0; w < 300 && i_slv.n < b + n; w++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		#1 chk("writes", i_slv.n - b, n);
		for (int i = 0; i < n; i++) begin
			chk("addr", i_slv.got_a[b + i], 32'hA0000100 + i);
			chk("word", i_slv.got_d[b + i], 32'h5A5A0000 + i);
		end
		chk("irq", irq, ctl[1]);
		rc(`TWS_OFS_IRQ, 32'h2);
		wr(`TWS_OFS_IRQ, 32'h2);
		rc(`TWS_OFS_IRQ, 32'h0);
		chk("irqoff", irq, 32'h0);
		rc(`TWS_OFS_INHIBIT, 32'h1);
	endtask
	task automatic t_inhibit;
		int b;
		b = i_slv.n;
		wr(`TWS_OFS_INHIBIT, 32'hFFFFFFFF);
		rc(`TWS_OFS_INHIBIT, 32'h1);
		fire;
		repeat (6) @(posedge clk);
		#1 chk("held", i_slv.n - b, 32'h0);
		rc(`TWS_OFS_IRQ, 32'h0);
		wr(`TWS_OFS_INHIBIT, 32'h0);
	endtask
	task automatic t_stream;
		int k;
		wr(`TWS_OFS_CONTROL, 32'h0);
		push(24'h0, 1'b1, 1'b0, ok);
		chk("gated", ok, 32'h0);
		wr(`TWS_OFS_CONTROL, 32'h1);
		push(24'h0, 1'b1, 1'b0, ok);
		chk("sop", ok, 32'h1);
		wr(`TWS_OFS_CONTROL, 32'h0);
		k = 1;
		ok = 1'b1;
		while (ok && k < 12) begin
			push(24'(k), 1'b0, 1'b0, ok);
			if (ok)
				k++;
		end
		chk("fill", k, 32'h8);
		rc(`TWS_OFS_STATUS, 32'h1);
		out_ready = 1'b1;
		for (int i = 0; i < 8; i++)
			pop(24'(i), i == 0, 1'b0);
		push(24'h8, 1'b0, 1'b1, ok);
		pop(24'h8, 1'b0, 1'b1);
		rc(`TWS_OFS_STATUS, 32'h0);
		push(24'h9, 1'b1, 1'b0, ok);
		chk("stopped", ok, 32'h0);
	endtask
	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up;
		end
	end
	// Main sequence.
	initial begin
		{reset_n, reg_write, reg_read, trigger_in, slow, in_valid, in_sop, in_eop, out_ready} = 9'h000;
		reg_address = 5'h00;
		reg_writedata = 32'h0;
		in_data = 24'h0;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		t_regs;
		t_run(10, 1'b0, 32'h3);
		t_run(3, 1'b1, 32'h3);
		t_inhibit;
		t_run(2, 1'b0, 32'h1);
		t_stream;
		wrap_up;
	end
endmodule // test_triggered_write_sequencer
bind tws_top tws_chk i_chk (.clk, .reset_n, .reg_address, .reg_write, .reg_writedata, .reg_read, .reg_readdata,
	.reg_readdatavalid, .trigger_in, .irq, .mst_address, .mst_write, .mst_writedata, .mst_waitrequest,
	.out_valid, .out_ready, .out_data);
`default_nettype wire

// >>> test/tws_assertions.sv
/* Port assertions of the triggered write sequencer.
   Assumes a bind to tws_top placed in the testbench top file. */
`timescale 1ns/10ps
`default_nettype none
module tws_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register port.
	input wire logic [4:0] reg_address,
	input wire logic reg_write,
	input wire logic [31:0] reg_writedata,
	input wire logic reg_read,
	input wire logic [31:0] reg_readdata,
	input wire logic reg_readdatavalid,
	// Trigger, interrupt and write port.
	input wire logic trigger_in,
	input wire logic irq,
	input wire logic [31:0] mst_address,
	input wire logic mst_write,
	input wire logic [31:0] mst_writedata,
	input wire logic mst_waitrequest,
	// Output stream.
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [23:0] out_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Register reads answer and keep spare bits at zero.
	chk_read_answer: assert property (reg_read |=> reg_readdatavalid)
		else $error("read not answered");
	chk_status_bits: assert property (reg_read && reg_address == 5'h01 |=> reg_readdata[31:1] == 31'h0)
		else $error("status spare bits set");
	chk_flag_bits: assert property (reg_read && reg_address == 5'h02 |=> reg_readdata[31:2] == 30'h0)
		else $error("flag spare bits set");
	// Interrupt clears on request and rises only once writes are over.
	chk_flag_clear: assert property (reg_write && reg_address == 5'h02 && reg_writedata[1]
		&& !mst_write && !$past(mst_write) && !trigger_in && !$past(trigger_in) |-> ##2 !irq)
		else $error("flag not cleared");
	chk_irq_late: assert property ($rose(irq) |-> !$past(mst_write) || $past(reg_write))
		else $error("irq during writes");
	// Writes start on a trigger, hold while stalled and end on acceptance; output beats hold while stalled.
	chk_run_start: assert property ($rose(mst_write) |-> $past(trigger_in))
		else $error("write without trigger");
	chk_write_hold: assert property (mst_write && mst_waitrequest |=>
		mst_write && $stable(mst_address) && $stable(mst_writedata)) else $error("write dropped");
	chk_end_accept: assert property ($fell(mst_write) |-> !$past(mst_waitrequest))
		else $error("write ended unaccepted");
	chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("beat dropped");
	// Main scenarios.
	cov_accept: cover property (mst_write && !mst_waitrequest);
	cov_irq: cover property ($rose(irq));
	cov_beat: cover property (out_valid && out_ready);
endmodule // tws_chk
`default_nettype wire

// >>> test/tws_slave_model.sv
/* Downstream control port model that takes the sequencer's writes.
   Assumes one clock shared with the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module tws_slave_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Write port and pacing.
	input wire logic [31:0] mst_address,
	input wire logic mst_write,
	input wire logic [31:0] mst_writedata,
	output logic mst_waitrequest,
	input wire logic slow
);
	logic [31:0] got_a [0:31];
	logic [31:0] got_d [0:31];
	logic [1:0] ph_r;
	int n;
	// Busy while idle; when slow, takes one write in four cycles.
	assign mst_waitrequest = !mst_write || (slow && ph_r != 2'h3);
	// Logs each accepted write in arrival order.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ph_r <= 2'h0;
			n <= 0;
		end else begin
			ph_r <= ph_r + 2'h1;
			if (mst_write && !mst_waitrequest) begin
				got_a[n[4:0]] <= mst_address;
				got_d[n[4:0]] <= mst_writedata;
				n <= n + 1;
			end
		end
	end
endmodule // tws_slave_model
`default_nettype wire
